// [sdrd_pkg.sv]
// ==========================================================================
// Shared constants for the selected-device register decode
package sdrd_pkg;

    // ======================================================================
    // Widths
    localparam int WORD_W = 16;      // PIO data word width
    localparam int REG_W = 8;        // Task-file register width
    localparam int BUS_AW = 8;       // Local register bus address width
    localparam int BUS_DW = 32;      // Local register bus data width
    localparam int EVT_W = 5;        // Number of interrupt events

    // ======================================================================
    // Address line codes {DA2, DA1, DA0}, 1 = asserted
    localparam logic [2:0] DA_DATA = 3'h0;   // Command block data
    localparam logic [2:0] DA_FEAT = 3'h1;   // Features / error
    localparam logic [2:0] DA_SCNT = 3'h2;   // Sector count
    localparam logic [2:0] DA_SNUM = 3'h3;   // Sector number
    localparam logic [2:0] DA_CYLL = 3'h4;   // Cylinder low
    localparam logic [2:0] DA_CYLH = 3'h5;   // Cylinder high
    localparam logic [2:0] DA_CTRL = 3'h6;   // Control block: control / alt status

    // ======================================================================
    // Device control register fields
    localparam int CTRL_NIEN_BIT = 1;   // Interrupt disable
    localparam int CTRL_SRST_BIT = 2;   // Software reset

    // ======================================================================
    // Reset values
    localparam logic [REG_W-1:0] TF_RST = 8'h00;      // Task-file registers
    localparam logic [REG_W-1:0] CTRL_RST = 8'h00;    // Device control
    localparam logic [EVT_W-1:0] EVT_RST = 5'h00;     // Sticky status / mask
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000; // Data words
    localparam logic [2:0] PIN3_RST = 3'h0;           // Address lines idle
    localparam logic [2:0] STRB_RST = 3'h7;           // CS0-, CS1-, strobe idle high

    // ======================================================================
    // Local register bus offsets (byte addresses)
    localparam logic [BUS_AW-1:0] OFS_IRQ_STAT = 8'h00;  // Sticky events, W1C
    localparam logic [BUS_AW-1:0] OFS_IRQ_MASK = 8'h04;  // Event enables
    localparam logic [BUS_AW-1:0] OFS_TASKFILE = 8'h08;  // {cylh, cyll, snum, scnt}
    localparam logic [BUS_AW-1:0] OFS_FEATCTRL = 8'h0c;  // {selected, ctrl, features}

    // ======================================================================
    // Event bit positions
    localparam int EVT_CTRL_WR = 0;   // Device control written
    localparam int EVT_TF_WR = 1;     // Task-file register loaded
    localparam int EVT_DATA_WR = 2;   // PIO word written by host
    localparam int EVT_DATA_RD = 3;   // PIO word read by host
    localparam int EVT_HOST_ERR = 4;  // Write refused while DRQ set, BSY clear

    // ======================================================================
    // Decoded target of a host cycle
    typedef enum logic [2:0] {
        SDRD_T_NONE = 3'b000,   // Ignored
        SDRD_T_CTRL = 3'b001,   // Device control / alternate status
        SDRD_T_DATA = 3'b010,   // Data register
        SDRD_T_FEAT = 3'b011,   // Features / error
        SDRD_T_SCNT = 3'b100,   // Sector count
        SDRD_T_SNUM = 3'b101,   // Sector number
        SDRD_T_CYLL = 3'b110,   // Cylinder low
        SDRD_T_CYLH = 3'b111    // Cylinder high
    } sdrd_target_t;

endpackage

// [sdrd_sync.sv]
`timescale 1ns/10ps
// ==========================================================================
// Two flip-flop synchroniser for a bundle of pin levels
module sdrd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;   // First stage, read only by second stage

    // Plain two-stage chain; bits are independent, so a skew of one
    // cycle between them is absorbed by the strobe-based capture downstream
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_r <= RST;
            o_sync <= RST;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // sdrd_sync

// [sdrd_strobe.sv]
`timescale 1ns/10ps
// ==========================================================================
// Active-low strobe tracker: level while asserted, pulse on negation
module sdrd_strobe (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_strobe_n,   // Already synchronised
    output logic o_active,
    output logic o_negate
);
    logic prev_n_r;   // Strobe level one cycle back

    // Remember last level to find the rising (negation) edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prev_n_r <= 1'b1;
        end else begin
            prev_n_r <= i_strobe_n;
        end
    end

    assign o_active = ~i_strobe_n;
    assign o_negate = i_strobe_n & ~prev_n_r;   // One pulse per host strobe
endmodule // sdrd_strobe

// [sdrd_decode.sv]
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// How it works
// RULE1: Decode only when DEV bit matches own number, except control writes, which load either way
// RULE2: Ignore strobes without chip select or bad control address
// RULE3: Control write loads nIEN and SRST always
// RULE4: Control read returns status, pending untouched
// RULE5: Data word moves only when BSY 0, DRQ 1
// RULE6: Features loads when BSY 0 and DRQ 0
// RULE7: Task-file writes dropped when BSY or DRQ set
// RULE8: Host never writes task file during DRQ
// RULE9: Error read when BSY 0
// RULE10: Task-file reads while BSY return status instead
// RULE11: Sector count loads when BSY 0, DRQ 0
// RULE12: Sector count read when BSY 0
// RULE13: Sector number loads when BSY 0, DRQ 0
// RULE14: Sector number read when BSY 0
// RULE15: Cylinder low loads when BSY 0, DRQ 0
// RULE16: Cylinder low read when BSY 0
// RULE17: Cylinder high loads when BSY 0, DRQ 0
// RULE18: Cylinder high read when BSY 0
// RULE19: Strobes synchronised, action committed on negation
module sdrd_decode (
    input wire logic i_clk,
    input wire logic i_reset,
    // Host pins, asynchronous
    input wire logic i_cs0_n,
    input wire logic i_cs1_n,
    input wire logic [2:0] i_da,
    input wire logic i_dior_n,
    input wire logic i_diow_n,
    input wire logic [sdrd_pkg::WORD_W-1:0] i_dd,
    output logic [sdrd_pkg::WORD_W-1:0] o_dd,
    output logic o_dd_oe,
    // Device core, same clock
    input wire logic i_dev_num,
    input wire logic i_dev_bit,
    input wire logic i_bsy,
    input wire logic i_drq,
    input wire logic [sdrd_pkg::REG_W-1:0] i_status,
    input wire logic [sdrd_pkg::REG_W-1:0] i_error,
    input wire logic [sdrd_pkg::WORD_W-1:0] i_rd_word,
    output logic o_rd_word_pop,
    output logic [sdrd_pkg::WORD_W-1:0] o_wr_word,
    output logic o_wr_word_valid,
    output logic o_selected,
    output logic o_nien,
    output logic o_srst,
    output logic [sdrd_pkg::REG_W-1:0] o_features,
    output logic [sdrd_pkg::REG_W-1:0] o_sector_count,
    output logic [sdrd_pkg::REG_W-1:0] o_sector_number,
    output logic [sdrd_pkg::REG_W-1:0] o_cyl_low,
    output logic [sdrd_pkg::REG_W-1:0] o_cyl_high,
    // Local register port
    input wire logic [sdrd_pkg::BUS_AW-1:0] i_reg_addr,
    input wire logic [sdrd_pkg::BUS_DW-1:0] i_reg_wdata,
    input wire logic i_reg_we,
    input wire logic i_reg_re,
    output logic [sdrd_pkg::BUS_DW-1:0] o_reg_rdata,
    output logic o_irq
);
    // ======================================================================
    // Pin synchronisation
    logic [2:0] strb_s;                        // {cs0_n, cs1_n, dior_n}
    logic [2:0] da_s;                          // Synchronised address
    logic [sdrd_pkg::WORD_W-1:0] dd_s;         // Synchronised data in
    logic dior_s_n;                            // Synchronised read strobe
    logic diow_s_n;                            // Synchronised write strobe
    logic rd_active;                           // Read strobe asserted
    logic rd_negate;                           // Read strobe just negated
    logic wr_active;                           // Write strobe asserted
    logic wr_negate;                           // Write strobe just negated

    // Chip selects and read strobe in one bundle, idle high
    sdrd_sync #(.W(3), .RST(sdrd_pkg::STRB_RST)) u_sync_ctl ( // [RULE19]
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_cs0_n, i_cs1_n, i_dior_n}),
        .o_sync(strb_s)
    );

    // Write strobe separately so the bundles stay readable
    sdrd_sync #(.W(1), .RST(1'b1)) u_sync_wr ( // [RULE19]
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_diow_n),
        .o_sync(diow_s_n)
    );

    // Address lines
    sdrd_sync #(.W(3), .RST(sdrd_pkg::PIN3_RST)) u_sync_da (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_da),
        .o_sync(da_s)
    );

    // Host data bus inputs
    sdrd_sync #(.W(sdrd_pkg::WORD_W), .RST(sdrd_pkg::WORD_RST)) u_sync_dd (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_dd),
        .o_sync(dd_s)
    );

    assign dior_s_n = strb_s[0];

    // Read strobe edges
    sdrd_strobe u_rd_strobe (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_strobe_n(dior_s_n),
        .o_active(rd_active),
        .o_negate(rd_negate)
    );

    // Write strobe edges
    sdrd_strobe u_wr_strobe (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_strobe_n(diow_s_n),
        .o_active(wr_active),
        .o_negate(wr_negate)
    );

    // ======================================================================
    // Address capture during the strobe
    logic cs0_lat_r;                             // CS0- held from strobe
    logic cs1_lat_r;                             // CS1- held from strobe
    logic [2:0] da_lat_r;                        // Address held from strobe
    logic [sdrd_pkg::WORD_W-1:0] wd_lat_r;       // Write data held from strobe

    // Host may drop address in the same cycle the negation reaches us, so
    // the values seen while the strobe was asserted are the ones used
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cs0_lat_r <= 1'b1;
            cs1_lat_r <= 1'b1;
            da_lat_r <= sdrd_pkg::PIN3_RST;
            wd_lat_r <= sdrd_pkg::WORD_RST;
        end else if (rd_active || wr_active) begin
            cs0_lat_r <= strb_s[2];
            cs1_lat_r <= strb_s[1];
            da_lat_r <= da_s;
            wd_lat_r <= dd_s;
        end
    end

    // ======================================================================
    // Address decode
    sdrd_pkg::sdrd_target_t live_tgt;   // Target from live synced pins
    sdrd_pkg::sdrd_target_t lat_tgt;    // Target from latched pins

    // Map chip selects and address to a target; everything else ignored
    function automatic sdrd_pkg::sdrd_target_t decode_target(
        input logic cs0_n, input logic cs1_n, input logic [2:0] da);
        sdrd_pkg::sdrd_target_t t;
        t = sdrd_pkg::SDRD_T_NONE;
        if (!cs1_n && cs0_n) begin
            // Control block: one address only
            if (da == sdrd_pkg::DA_CTRL) begin // [RULE2]
                t = sdrd_pkg::SDRD_T_CTRL;
            end
        end else if (!cs0_n && cs1_n) begin
            case (da)
                sdrd_pkg::DA_DATA: t = sdrd_pkg::SDRD_T_DATA;
                sdrd_pkg::DA_FEAT: t = sdrd_pkg::SDRD_T_FEAT;
                sdrd_pkg::DA_SCNT: t = sdrd_pkg::SDRD_T_SCNT;
                sdrd_pkg::DA_SNUM: t = sdrd_pkg::SDRD_T_SNUM;
                sdrd_pkg::DA_CYLL: t = sdrd_pkg::SDRD_T_CYLL;
                sdrd_pkg::DA_CYLH: t = sdrd_pkg::SDRD_T_CYLH;
                // Device/head and command handled elsewhere
                default: t = sdrd_pkg::SDRD_T_NONE;
            endcase
        end
        // Neither or both selects asserted: ignored [RULE2]
        return t;
    endfunction

    assign live_tgt = decode_target(strb_s[2], strb_s[1], da_s);
    assign lat_tgt = decode_target(cs0_lat_r, cs1_lat_r, da_lat_r);
    assign o_selected = (i_dev_bit == i_dev_num); // [RULE1]

    // ======================================================================
    // Commit conditions at strobe negation
    logic tf_wr_ok;     // Task-file write may load
    logic wr_commit;    // Selected write ends now
    logic rd_commit;    // Selected read ends now
    logic data_ok;      // Data phase open

    assign data_ok = !i_bsy && i_drq;                          // [RULE5]
    assign tf_wr_ok = !i_bsy && !i_drq;                        // [RULE7]
    assign wr_commit = wr_negate && o_selected;                // [RULE19] [RULE1]
    assign rd_commit = rd_negate && o_selected;                // [RULE19] [RULE1]

    // ======================================================================
    // Device control register
    logic [sdrd_pkg::REG_W-1:0] ctrl_r;   // Last written control byte

    // Loaded whatever BSY and DRQ say
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_r <= sdrd_pkg::CTRL_RST;
        end else if (wr_negate && lat_tgt == sdrd_pkg::SDRD_T_CTRL) begin
            ctrl_r <= wd_lat_r[sdrd_pkg::REG_W-1:0]; // [RULE3]
        end
    end

    assign o_nien = ctrl_r[sdrd_pkg::CTRL_NIEN_BIT];   // [RULE3]
    assign o_srst = ctrl_r[sdrd_pkg::CTRL_SRST_BIT];   // [RULE3]

    // ======================================================================
    // Command block task-file registers
    logic [sdrd_pkg::REG_W-1:0] feat_r;   // Features
    logic [sdrd_pkg::REG_W-1:0] scnt_r;   // Sector count
    logic [sdrd_pkg::REG_W-1:0] snum_r;   // Sector number
    logic [sdrd_pkg::REG_W-1:0] cyll_r;   // Cylinder low
    logic [sdrd_pkg::REG_W-1:0] cylh_r;   // Cylinder high
    logic tf_load;                        // A task-file load happens now

    assign tf_load = wr_commit && tf_wr_ok && (lat_tgt > sdrd_pkg::SDRD_T_DATA);

    // Writes outside BSY 0 / DRQ 0 leave every task-file register untouched
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            feat_r <= sdrd_pkg::TF_RST;
            scnt_r <= sdrd_pkg::TF_RST;
            snum_r <= sdrd_pkg::TF_RST;
            cyll_r <= sdrd_pkg::TF_RST;
            cylh_r <= sdrd_pkg::TF_RST;
        end else if (tf_load) begin // [RULE7]
            case (lat_tgt)
                sdrd_pkg::SDRD_T_FEAT: feat_r <= wd_lat_r[7:0];   // [RULE6]
                sdrd_pkg::SDRD_T_SCNT: scnt_r <= wd_lat_r[7:0];   // [RULE11]
                sdrd_pkg::SDRD_T_SNUM: snum_r <= wd_lat_r[7:0];   // [RULE13]
                sdrd_pkg::SDRD_T_CYLL: cyll_r <= wd_lat_r[7:0];   // [RULE15]
                sdrd_pkg::SDRD_T_CYLH: cylh_r <= wd_lat_r[7:0];   // [RULE17]
                default: feat_r <= feat_r;
            endcase
        end
    end

    assign o_features = feat_r;
    assign o_sector_count = scnt_r;
    assign o_sector_number = snum_r;
    assign o_cyl_low = cyll_r;
    assign o_cyl_high = cylh_r;

    // ======================================================================
    // PIO data word transfer
    // One word per strobe; the core sees a pulse for each direction
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_wr_word <= sdrd_pkg::WORD_RST;
            o_wr_word_valid <= 1'b0;
            o_rd_word_pop <= 1'b0;
        end else begin
            o_wr_word_valid <= wr_commit && data_ok
                && lat_tgt == sdrd_pkg::SDRD_T_DATA; // [RULE5]
            o_rd_word_pop <= rd_commit && data_ok
                && lat_tgt == sdrd_pkg::SDRD_T_DATA; // [RULE5]
            if (wr_commit && data_ok && lat_tgt == sdrd_pkg::SDRD_T_DATA) begin
                o_wr_word <= wd_lat_r;
            end
        end
    end

    // ======================================================================
    // Read data path
    logic [sdrd_pkg::WORD_W-1:0] rd_mux;   // Word for the live address
    logic rd_drive;                        // Live read is answered

    // Byte registers sit in the low lane; BSY substitutes status
    always_comb begin
        rd_mux = sdrd_pkg::WORD_RST;
        rd_drive = 1'b1;
        case (live_tgt)
            sdrd_pkg::SDRD_T_CTRL: rd_mux[7:0] = i_status;   // [RULE4]
            sdrd_pkg::SDRD_T_DATA: begin
                rd_mux = i_rd_word;
                rd_drive = data_ok;                         // [RULE5]
            end
            sdrd_pkg::SDRD_T_FEAT: rd_mux[7:0] = i_bsy ? i_status : i_error;  // [RULE9] [RULE10]
            sdrd_pkg::SDRD_T_SCNT: rd_mux[7:0] = i_bsy ? i_status : scnt_r;   // [RULE12] [RULE10]
            sdrd_pkg::SDRD_T_SNUM: rd_mux[7:0] = i_bsy ? i_status : snum_r;   // [RULE14] [RULE10]
            sdrd_pkg::SDRD_T_CYLL: rd_mux[7:0] = i_bsy ? i_status : cyll_r;   // [RULE16] [RULE10]
            sdrd_pkg::SDRD_T_CYLH: rd_mux[7:0] = i_bsy ? i_status : cylh_r;   // [RULE18] [RULE10]
            default: rd_drive = 1'b0;                       // [RULE2]
        endcase
    end

    // Registered pin drive; status reads here touch no pending state
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_dd <= sdrd_pkg::WORD_RST;
            o_dd_oe <= 1'b0;
        end else begin
            o_dd_oe <= rd_active && o_selected && rd_drive;   // [RULE1] [RULE4]
            if (rd_active) begin
                o_dd <= rd_mux;
            end
        end
    end

    // ======================================================================
    // Interrupt events
    logic [sdrd_pkg::EVT_W-1:0] evt_set;    // Events this cycle
    logic [sdrd_pkg::EVT_W-1:0] irq_stat_r; // Sticky events
    logic [sdrd_pkg::EVT_W-1:0] irq_mask_r; // Enables
    logic [sdrd_pkg::EVT_W-1:0] stat_clr;   // Write-one-to-clear bits

    // A task-file write during DRQ with BSY clear is a host fault; flag it
    always_comb begin
        evt_set = sdrd_pkg::EVT_RST;
        evt_set[sdrd_pkg::EVT_CTRL_WR] = wr_negate && lat_tgt == sdrd_pkg::SDRD_T_CTRL;
        evt_set[sdrd_pkg::EVT_TF_WR] = tf_load;
        evt_set[sdrd_pkg::EVT_DATA_WR] = wr_commit && data_ok
            && lat_tgt == sdrd_pkg::SDRD_T_DATA;
        evt_set[sdrd_pkg::EVT_DATA_RD] = rd_commit && data_ok
            && lat_tgt == sdrd_pkg::SDRD_T_DATA;
        evt_set[sdrd_pkg::EVT_HOST_ERR] = wr_commit && data_ok
            && lat_tgt > sdrd_pkg::SDRD_T_DATA; // [RULE8]
    end

    assign stat_clr = (i_reg_we && i_reg_addr == sdrd_pkg::OFS_IRQ_STAT)
        ? i_reg_wdata[sdrd_pkg::EVT_W-1:0] : sdrd_pkg::EVT_RST;

    // Set beats clear so no event is lost in the clearing cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_stat_r <= sdrd_pkg::EVT_RST;
        end else begin
            irq_stat_r <= (irq_stat_r & ~stat_clr) | evt_set;
        end
    end

    // Mask register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_mask_r <= sdrd_pkg::EVT_RST;
        end else if (i_reg_we && i_reg_addr == sdrd_pkg::OFS_IRQ_MASK) begin
            irq_mask_r <= i_reg_wdata[sdrd_pkg::EVT_W-1:0];
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    // ======================================================================
    // Local register read port
    // Data one cycle after the read strobe, zero elsewhere and when unmapped
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_reg_rdata <= '0;
        end else if (i_reg_re) begin
            case (i_reg_addr)
                sdrd_pkg::OFS_IRQ_STAT: o_reg_rdata <= {27'h0, irq_stat_r};
                sdrd_pkg::OFS_IRQ_MASK: o_reg_rdata <= {27'h0, irq_mask_r};
                sdrd_pkg::OFS_TASKFILE: o_reg_rdata <= {cylh_r, cyll_r, snum_r, scnt_r};
                sdrd_pkg::OFS_FEATCTRL: o_reg_rdata <= {15'h0, o_selected, ctrl_r, feat_r};
                default: o_reg_rdata <= '0;
            endcase
        end else begin
            o_reg_rdata <= '0;
        end
    end
endmodule // sdrd_decode

// [sdrd_checker.sv]
`timescale 1ns/10ps
// ========================================
// Port checks on the host register decode
module sdrd_checker (
    input wire logic i_clk, i_reset, i_dior_n, i_diow_n, i_dev_num, i_dev_bit, i_bsy, i_drq,
    input wire logic i_reg_re, o_dd_oe, o_rd_word_pop, o_wr_word_valid, o_selected,
    input wire logic o_nien, o_srst,
    input wire logic [sdrd_pkg::REG_W-1:0] o_features, o_sector_count, o_sector_number,
    input wire logic [sdrd_pkg::REG_W-1:0] o_cyl_low, o_cyl_high,
    input wire logic [sdrd_pkg::BUS_DW-1:0] o_reg_rdata
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire logic busy = i_bsy | i_drq; // Any state that blocks task-file loads
    wire logic [41:0] regs = {o_nien, o_srst, o_features, o_sector_count, o_sector_number,
        o_cyl_low, o_cyl_high}; // Every host-loaded control and task-file register
    a_sel_match: assert property (o_selected == (i_dev_bit == i_dev_num))
        else $error("selected flag disagrees with device bit");
    a_oe_after_rd: assert property (o_dd_oe |-> !$past(i_dior_n, 3))
        else $error("data bus driven without a synced read strobe");
    a_pop_cause: assert property (o_rd_word_pop |-> !$past(i_bsy) && $past(i_drq))
        else $error("word popped outside data phase");
    a_wv_cause: assert property (o_wr_word_valid |-> !$past(i_bsy) && $past(i_drq))
        else $error("word written outside data phase");
    a_pulse_once: assert property ((o_rd_word_pop || o_wr_word_valid) |=>
        !(o_rd_word_pop || o_wr_word_valid)) else $error("data pulse longer than one cycle");
    a_tf_gate: assert property ($changed(regs[39:0]) |-> !$past(busy) && !$past(busy, 2))
        else $error("task-file register changed while busy or in data phase");
    a_commit_neg: assert property ($changed(regs) |-> $past(i_diow_n) && $past(i_diow_n, 2))
        else $error("register loaded before write strobe negated");
    a_rdata_zero: assert property (!$past(i_reg_re) |-> o_reg_rdata == '0)
        else $error("register read data outside its cycle");
    // Main scenarios reached
    c_pop: cover property (o_rd_word_pop);
    c_wr: cover property (o_wr_word_valid);
    c_ctrl_busy: cover property ($rose(o_srst) && i_bsy);
endmodule // sdrd_checker

// [sdrd_host_model.sv]
`timescale 1ns/10ps
// ========================================
// Host adapter issuing one register cycle at a time
module sdrd_host_model (
    input wire logic i_clk,
    input wire logic i_dd_oe,
    input wire logic [sdrd_pkg::WORD_W-1:0] i_dd,
    output logic o_cs0_n, o_cs1_n, o_dior_n, o_diow_n,
    output logic [2:0] o_da,
    output logic [sdrd_pkg::WORD_W-1:0] o_dd
);
    // Idle pins at time zero, strobes negated
    initial {o_cs1_n, o_cs0_n, o_dior_n, o_diow_n, o_da, o_dd} = {4'hf, 3'h0, 16'h0000};
    // Strobe held four clocks, then four idle clocks, one strobe at a time
    // Callers write the task file under DRQ only to probe refusal
    task automatic cyc(input logic w, input logic [1:0] csn, input logic [2:0] da,
        input logic [15:0] d, output logic [16:0] q);
        @(posedge i_clk);
        {o_cs1_n, o_cs0_n, o_da, o_dd, o_diow_n, o_dior_n} <= {csn, da, d, !w, w};
        repeat (4) @(posedge i_clk);
        q = {i_dd_oe, i_dd}; // Taken while strobe still asserted
        {o_diow_n, o_dior_n} <= 2'h3;
        repeat (4) @(posedge i_clk);
        // Chip selects go idle; address and data show the inverse, never a stale copy
        {o_cs1_n, o_cs0_n, o_da, o_dd} <= {2'h3, ~da, ~d};
    endtask
endmodule // sdrd_host_model

// [tb_top.sv]
`timescale 1ns/10ps
// ========================================
// Bench: table of host cycles, then hand-written cases
module tb_top;
    typedef struct packed {logic w; logic [1:0] csn; logic [2:0] da; logic bsy, drq;
        logic [15:0] d, e;} sdrd_row_t;
    logic i_clk = 0, i_reset = 1, i_cs0_n, i_cs1_n, i_dior_n, i_diow_n, i_dev_num = 0;
    logic i_dev_bit = 0, i_bsy = 0, i_drq = 0, i_reg_we = 0, i_reg_re = 0, o_dd_oe, o_irq;
    logic o_rd_word_pop, o_wr_word_valid, o_selected, o_nien, o_srst;
    logic [2:0] i_da;
    logic [15:0] i_dd, o_dd, o_wr_word, i_rd_word = 16'hbeef;
    logic [7:0] i_status = 8'h5a, i_error = 8'h3c, i_reg_addr = 8'h00, o_features;
    logic [7:0] o_sector_count, o_sector_number, o_cyl_low, o_cyl_high;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, r;
    logic [16:0] q;
    int fail_count = 0, n_compared = 0, cycles = 0;
    wire logic [39:0] tfv = {o_cyl_high, o_cyl_low, o_sector_number, o_sector_count, o_features};
    // Writes expect the register after, reads the bus value; csn is {cs1_n, cs0_n}
    sdrd_row_t rows[17] = '{'{1,2,1,0,0,'h11,'h11}, '{1,2,2,0,0,'h22,'h22},
        '{1,2,3,0,0,'h33,'h33}, '{1,2,4,0,0,'h44,'h44}, '{1,2,5,0,0,'h55,'h55},
        '{1,2,2,0,1,'h99,'h22}, '{1,2,3,1,0,'h99,'h33}, '{1,2,5,1,1,'h99,'h55},
        '{0,2,1,0,1,0,'h3c}, '{0,2,2,0,1,0,'h22}, '{0,2,3,0,0,0,'h33}, '{0,2,4,0,0,0,'h44},
        '{0,2,5,0,1,0,'h55}, '{0,2,2,1,0,0,'h5a}, '{0,2,5,1,1,0,'h5a}, '{0,1,6,1,0,0,'h5a},
        '{0,2,0,0,1,0,'hbeef}};
    sdrd_decode uut (.*);
    sdrd_host_model host (.i_clk(i_clk), .i_dd_oe(o_dd_oe), .i_dd(o_dd), .o_cs0_n(i_cs0_n),
        .o_cs1_n(i_cs1_n), .o_dior_n(i_dior_n), .o_diow_n(i_diow_n), .o_da(i_da), .o_dd(i_dd));
    always #2.5 i_clk = ~i_clk;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_clk) if (++cycles == 3000) begin
        fail_count++;
        close_out();
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Register port cycle; read data taken the cycle after the strobe
    task automatic rop(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_reg_addr, i_reg_wdata, i_reg_we, i_reg_re} <= {a, d, w, !w};
        @(posedge i_clk);
        {i_reg_we, i_reg_re} <= 2'h0;
        #1 r = o_reg_rdata;
    endtask
    // Reset held n clocks with idle pins; every cleared output except o_dd must read zero
    task automatic rst(input int n);
        i_reset <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        chk("reset", 0, {tfv[39:16] | tfv[23:0], o_nien, o_srst, o_irq, o_dd_oe, o_rd_word_pop,
            o_wr_word_valid, |o_reg_rdata, |o_wr_word});
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        rst(16);
        foreach (rows[k]) begin
            {i_bsy, i_drq} <= {rows[k].bsy, rows[k].drq};
            host.cyc(rows[k].w, rows[k].csn, rows[k].da, rows[k].d, q);
            chk("row", {!rows[k].w, rows[k].e}, rows[k].w ? tfv[(rows[k].da-1)*8 +: 8] : q);
        end
        host.cyc(1, 2, 0, 16'h1234, q);
        {i_bsy, i_drq} <= 2'h0;
        host.cyc(1, 2, 0, 16'h4321, q);
        host.cyc(0, 2, 0, 16'h0, q);
        chk("data word", {1'b0, 16'h1234}, {q[16], o_wr_word});
        i_bsy <= 1'b1;
        host.cyc(1, 1, 6, 16'h0006, q);
        host.cyc(1, 1, 7, 16'h0, q);
        host.cyc(1, 3, 6, 16'h0, q);
        host.cyc(1, 0, 6, 16'h0, q);
        chk("control", 2'h3, {o_nien, o_srst});
        {i_bsy, i_dev_bit} <= 2'h1;
        host.cyc(1, 2, 1, 16'h77, q);
        chk("unselected", {1'b0, 8'h11}, {o_selected, o_features});
        i_dev_bit <= 1'b0;
        rop(0, sdrd_pkg::OFS_TASKFILE, 0);
        chk("taskfile", 32'h55443322, r);
        rop(0, sdrd_pkg::OFS_FEATCTRL, 0);
        chk("featctrl", 32'h00010611, r);
        rop(0, sdrd_pkg::OFS_IRQ_STAT, 0);
        chk("status", 32'h1f, r);
        rop(1, sdrd_pkg::OFS_IRQ_MASK, 0);
        chk("masked irq", 0, o_irq);
        rop(1, sdrd_pkg::OFS_IRQ_MASK, 32'h10);
        chk("irq", 1, o_irq);
        rop(1, sdrd_pkg::OFS_IRQ_STAT, 32'h1f);
        rop(0, sdrd_pkg::OFS_IRQ_STAT, 0);
        chk("cleared", 0, {r[31:1], r[0] | o_irq});
        rop(0, 8'h40, 0);
        chk("unmapped", 0, r);
        rst(3);
        close_out();
    end
endmodule // tb_top
bind sdrd_decode sdrd_checker u_chk (.*);
